// file: verilog/shata_tile_alloc.sv
// Purpose: sector seed, ack seed and ack tile allocation engine
// Assumes: generator answers permRdData in the cycle of permRdAddr
// Notes: config writes are ignored while busy
module shata_tile_alloc
  import shata_pkg::*;
#(
  parameter int PERM_MAX = 16     // largest subband or block count
)
(
  input  wire logic        ref_clk,        // system clock
  input  wire logic        sys_rst,        // sync reset, high
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb access phase
  input  wire logic        pwrite,         // apb write
  input  wire logic [7:0]  paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic [31:0]      prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // unmapped address
  output logic             permReqValid,   // generator request pulse
  output logic [19:0]      permSeed,       // generator seed
  output logic [15:0]      permSize,       // generator size
  input  wire logic        permDone,       // generator finished
  output logic [$clog2(PERM_MAX)-1:0] permRdAddr, // entry index
  input  wire logic [$clog2(PERM_MAX)-1:0] permRdData, // entry value
  output logic             tileValid,      // tile accepted pulse
  output logic [15:0]      tileIndex,      // tile number
  output logic [$clog2(PERM_MAX)-1:0] tileSubband, // subband
  output logic [$clog2(PERM_MAX)-1:0] tileBlock,   // block
  output logic [15:0]      tileSubcarrier, // first hop-port subcarrier
  output logic [7:0]       tileSymFirst,   // first symbol
  output logic [7:0]       tileSymLast,    // last symbol
  output logic [11:0]      globalHopOffset // offset for global hop
);
  localparam int IW = $clog2(PERM_MAX);

  typedef struct packed {
    shata_phase_type ph;
    logic rdy, err;
    logic [31:0] rdata;
    logic [11:0] pilot;
    logic [31:0] sf;
    logic [5:0] j;
    logic [3:0] s;
    logic [1:0] c, q;
    logic tdd, intra;
    logic [3:0] code;
    logic [7:0] burst;
    logic [15:0] nodes, restr, ctlm;
    logic [IW:0] sCnt, bCnt, ng;
    logic [7:0] bw, dur, fsym, pre, symq;
    logic busy, done, short;
    logic [19:0] secSeed, ackSeed;
    logic [15:0] ntiles, tile;
    logic [11:0] gOff;
    logic hReq;
    logic [31:0] hArg;
    logic pReq;
    logic [19:0] pSeed;
    logic [15:0] pSize;
    logic [IW-1:0] pAddr;
    logic rdPh;
    logic [IW:0] rdIdx;
    logic [PERM_MAX-1:0][IW-1:0] subPerm, blkPerm, blkCnt;
    logic [IW-1:0] ptr;
    logic [2*IW+1:0] iter;
    logic tVal;
    logic [15:0] tIdx, tSc;
    logic [IW-1:0] tSub, tBlk;
    logic [7:0] tFirst, tLast;
  } shata_state_type;

  shata_state_type r, n;
  shata_hash_if hif ();

  logic [11:0] pOff, pOn, pSec;
  logic tddSlave, fr0, accept, setup, wrAcc, mapped, advance;
  logic [5:0] jTerm;
  logic [31:0] secArg, ackArg, rdMux;
  logic [15:0] nt, nodeQ, symQ, subL;
  logic [7:0] nSubt;
  logic [IW-1:0] sCand, bCand;
  logic [2*IW+1:0] itMax;

  shata_seed_hash u_hash (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .hif     (hif)
  );

  assign hif.req = r.hReq;
  assign hif.arg = r.hArg;

  // sector offsets and hash arguments
  always_comb
  begin
    pOff = r.pilot ^ r.sf[11:0];                  // R1
    pOn = {pOff[11:8], r.sf[7:5], pOff[4:0]};     // R2
    pSec = r.intra ? pOn : pOff;                  // R3
    tddSlave = r.tdd && (r.code == CODE_TDD_SLAVE);
    jTerm = tddSlave ? 6'(shata_div({18'h0, r.j}, {8'h00, r.burst}))
                     : r.j;                       // R5
    secArg = (tddSlave ? 32'h0 : LEAD_SEC)        // R4
           + (32'(r.q) << SH_Q) + (32'(r.c) << SH_CSEC)
           + (32'(r.s) << SH_S) + (32'(jTerm) << SH_J) + 32'(pSec);
    ackArg = LEAD_ACK + (32'(r.c) << SH_CACK)      // R9
           + (32'(r.j) << SH_J) + 32'(pOff);
    nodeQ = 16'(shata_div({7'h00, r.nodes, 1'b0},
                          16'(r.dur) * 16'(r.bw)));
    nSubt = 8'(shata_div({16'h0, r.fsym}, {8'h00, r.dur})); // R19
    nt = (r.nodes == 16'h0000) ? 16'h0000         // R8
       : ((nodeQ > 16'(nSubt)) ? nodeQ : 16'(nSubt));
    symQ = 16'(shata_div({16'h0, r.symq}, {8'h00, r.dur})); // R19
    subL = 16'(r.bw) * 16'(r.dur);                // R20
    fr0 = !r.tdd && (r.j == 6'h00);
  end

  // candidate tile and acceptance test
  always_comb
  begin
    sCand = r.subPerm[r.ptr];                     // R13
    bCand = r.blkPerm[r.blkCnt[sCand]];           // R13
    accept = ((IW+1)'(bCand) < r.ng)              // R14
           && !r.ctlm[sCand]                      // R14
           && !r.restr[sCand];                    // R15
    itMax = (2*IW+2)'(r.sCnt) * (2*IW+2)'(r.bCnt);
    advance = (r.tile < r.ntiles) && (r.iter != itMax);
  end

  // apb decode and read mux
  always_comb
  begin
    setup = psel && !penable;
    wrAcc = psel && penable && pwrite && r.rdy;
    mapped = (paddr[1:0] == 2'b00) && (paddr <= A_SUBL);
    case (paddr)
      A_CTRL:  rdMux = {29'h0, r.intra, r.tdd, 1'b0};
      A_PILOT: rdMux = {20'h0, r.pilot};           // R21
      A_SFIDX: rdMux = r.sf;
      A_INDEX: rdMux = {6'h0, r.q, 6'h0, r.c, 4'h0, r.s, 2'h0, r.j};
      A_SEED:  rdMux = {16'h0, r.burst, 4'h0, r.code};
      A_NODES: rdMux = {16'h0, r.nodes};
      A_MASK:  rdMux = {r.ctlm, r.restr};
      A_GEOM:  rdMux = {8'h0, 3'(0), r.ng, 3'(0), r.bCnt, 3'(0), r.sCnt};
      A_TIME:  rdMux = {r.pre, r.fsym, r.dur, r.bw};
      A_STAT:  rdMux = {24'h0, 4'(r.ph), 1'b0, r.short, r.done, r.busy};
      A_SSEED: rdMux = {12'h0, r.secSeed};
      A_ASEED: rdMux = {12'h0, r.ackSeed};
      A_TILES: rdMux = {8'h0, nSubt, r.ntiles};
      A_GOFF:  rdMux = {20'h0, r.gOff};
      A_SYMQ:  rdMux = {symQ, 8'h0, r.symq};
      A_SUBL:  rdMux = {16'h0, subL};
      default: rdMux = 32'h0;
    endcase
  end

  // next state
  always_comb
  begin
    n = r;
    n.rdy = setup;
    n.err = setup && !mapped;
    if (setup && !pwrite)
    begin
      n.rdata = mapped ? rdMux : 32'h0;
    end
    n.tVal = 1'b0;
    n.hReq = 1'b0;
    n.pReq = 1'b0;
    // config writes, ignored while busy to keep inputs stable
    if (wrAcc && !r.busy)
    begin
      case (paddr)
        A_CTRL:
        begin
          n.tdd = pwdata[CTRL_TDD];
          n.intra = pwdata[CTRL_INTRA];
        end
        A_PILOT: n.pilot = pwdata[11:0];           // R21
        A_SFIDX: n.sf = pwdata;
        A_INDEX:
        begin
          n.j = pwdata[IX_J +: 6];
          n.s = pwdata[IX_S +: 4];
          n.c = pwdata[IX_C +: 2];
          n.q = pwdata[IX_Q +: 2];
        end
        A_SEED:
        begin
          n.code = pwdata[3:0];
          n.burst = pwdata[SD_BURST +: 8];
        end
        A_NODES: n.nodes = pwdata[15:0];
        A_MASK:
        begin
          n.restr = pwdata[15:0];
          n.ctlm = pwdata[MK_CTL +: 16];
        end
        A_GEOM:
        begin
          n.sCnt = pwdata[IW:0];
          n.bCnt = pwdata[GM_B +: IW+1];
          n.ng = pwdata[GM_NG +: IW+1];
        end
        A_TIME:
        begin
          n.bw = pwdata[7:0];
          n.dur = pwdata[TM_DUR +: 8];
          n.fsym = pwdata[TM_FSYM +: 8];
          n.pre = pwdata[TM_PRE +: 8];
        end
        A_SYMQ:  n.symq = pwdata[7:0];
        default: n.symq = r.symq;
      endcase
    end
    case (r.ph)
      PH_IDLE:
      begin
        if (wrAcc && !r.busy && paddr == A_CTRL && pwdata[CTRL_START])
        begin
          n.busy = 1'b1;
          n.done = 1'b0;
          n.short = 1'b0;
          n.ntiles = nt;                           // R8
          n.ph = PH_SEC_HASH;
        end
      end
      PH_SEC_HASH:
      begin
        if (hif.done)
        begin
          n.secSeed = hif.seed;                    // R6
          n.pReq = 1'b1;                           // R22
          n.pSeed = hif.seed;                      // R7
          n.pSize = 16'(r.ng);                     // R7
          n.ph = PH_SEC_WAIT;
        end
        else if (!r.hReq)
        begin
          // a cycle after start, so flags written with start are used
          n.gOff = (r.code == CODE_GLOB_SECT) ? pSec : r.sf[11:0]; // R23
          n.hReq = 1'b1;
          n.hArg = secArg;
        end
      end
      PH_SEC_WAIT:
      begin
        if (permDone)                              // R22
        begin
          n.hReq = 1'b1;
          n.hArg = ackArg;
          n.ph = PH_ACK_HASH;
        end
      end
      PH_ACK_HASH:
      begin
        if (hif.done)
        begin
          n.ackSeed = hif.seed;
          n.pReq = 1'b1;
          n.pSeed = hif.seed;                      // R10
          n.pSize = 16'(r.sCnt);                   // R10
          n.ph = PH_SUB_WAIT;
        end
      end
      PH_SUB_WAIT, PH_BLK_WAIT:
      begin
        if (permDone)                              // R22
        begin
          n.rdIdx = '0;
          n.rdPh = 1'b0;
          n.ph = (r.ph == PH_SUB_WAIT) ? PH_SUB_RD : PH_BLK_RD;
        end
      end
      PH_SUB_RD, PH_BLK_RD:
      begin
        // address one cycle, capture the next
        if (!r.rdPh)
        begin
          n.pAddr = r.rdIdx[IW-1:0];
          n.rdPh = 1'b1;
        end
        else
        begin
          n.rdPh = 1'b0;
          n.rdIdx = r.rdIdx + 1'b1;
          if (r.ph == PH_SUB_RD)
          begin
            n.subPerm[r.rdIdx[IW-1:0]] = permRdData;
            if (r.rdIdx + 1'b1 >= r.sCnt)
            begin
              n.pReq = 1'b1;
              n.pSeed = r.ackSeed;                 // R11
              n.pSize = 16'(r.bCnt);               // R11
              n.ph = PH_BLK_WAIT;
            end
          end
          else
          begin
            n.blkPerm[r.rdIdx[IW-1:0]] = permRdData;
            if (r.rdIdx + 1'b1 >= r.bCnt)
            begin
              n.ptr = '0;                          // R12
              n.tile = 16'h0000;                   // R12
              n.blkCnt = '0;                       // R12
              n.iter = '0;
              n.ph = PH_ALLOC;
            end
          end
        end
      end
      PH_ALLOC:
      begin
        if (advance)
        begin
          n.iter = r.iter + 1'b1;
          n.blkCnt[sCand] = r.blkCnt[sCand] + 1'b1; // R13
          n.ptr = ((IW+1)'(r.ptr) + 1'b1 >= r.sCnt) ? '0 : r.ptr + 1'b1; // R13
          if (accept)
          begin
            n.tVal = 1'b1;
            n.tIdx = r.tile;                       // R18
            n.tile = r.tile + 1'b1;                // R18
            n.tSub = sCand;
            n.tBlk = bCand;
            n.tSc = 16'((16'(sCand) * 16'(r.bCnt) + 16'(bCand))
                      * 16'(r.bw));                // R16
            n.tFirst = fr0 ? r.pre : 8'h00;        // R17
            n.tLast = fr0 ? 8'(r.pre + r.fsym - 8'h01)
                          : 8'(r.fsym - 8'h01);    // R16
          end
        end
        else
        begin
          // tile count or iteration cap ends the sweep; short if it did not fill
          n.short = (r.tile < r.ntiles);
          n.busy = 1'b0;
          n.done = 1'b1;
          n.ph = PH_IDLE;
        end
      end
      default: n.ph = PH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.ph <= PH_IDLE;
      r.burst <= RST_ONE8;
      r.dur <= RST_ONE8;
      r.sf <= RST_WORD;
    end
    else
    begin
      r <= n;
    end
  end

  assign prdata = r.rdata;
  assign pready = r.rdy;
  assign pslverr = r.err;
  assign permReqValid = r.pReq;
  assign permSeed = r.pSeed;
  assign permSize = r.pSize;
  assign permRdAddr = r.pAddr;
  assign tileValid = r.tVal;
  assign tileIndex = r.tIdx;
  assign tileSubband = r.tSub;
  assign tileBlock = r.tBlk;
  assign tileSubcarrier = r.tSc;
  assign tileSymFirst = r.tFirst;
  assign tileSymLast = r.tLast;
  assign globalHopOffset = r.gOff;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  property p_r1_off;
    (r.ph == PH_SEC_HASH && r.hReq && !r.intra)
      |-> r.hArg[11:0] == (r.pilot ^ r.sf[11:0]);
  endproperty
  a_r1_off: assert property (p_r1_off) else $error("first offset wrong"); // R1
  property p_r2_on;
    (r.ph == PH_SEC_HASH && r.hReq && r.intra)
      |-> r.hArg[7:5] == r.sf[7:5] && r.hArg[4:0] == (r.pilot[4:0] ^ r.sf[4:0]);
  endproperty
  a_r2_on: assert property (p_r2_on) else $error("second offset wrong"); // R2
  property p_r5_lead;
    (r.ph == PH_SEC_HASH && r.hReq)
      |-> (r.hArg[26] == !tddSlave) && (r.hArg[31:27] == 5'h00);
  endproperty
  a_r5_lead: assert property (p_r5_lead) else $error("lead term wrong"); // R5
  property p_r9_ack;
    (r.ph == PH_ACK_HASH && r.hReq)
      |-> r.hArg[11:0] == pOff && r.hArg[17:12] == r.j && r.hArg[31:22] == 10'h001;
  endproperty
  a_r9_ack: assert property (p_r9_ack) else $error("ack hash arg wrong"); // R9
  property p_r8_zero;
    (r.busy && r.nodes == 16'h0000) |-> r.ntiles == 16'h0000;
  endproperty
  a_r8_zero: assert property (p_r8_zero) else $error("tiles without nodes"); // R8
  property p_r14_rej;
    r.tVal |-> ((IW+1)'(r.tBlk) < r.ng) && !r.ctlm[r.tSub];
  endproperty
  a_r14_rej: assert property (p_r14_rej) else $error("guard or control tile"); // R14
  property p_r15_mask;
    r.tVal |-> !r.restr[r.tSub];
  endproperty
  a_r15_mask: assert property (p_r15_mask) else $error("restricted tile"); // R15
  property p_r17_sym;
    (r.tVal && fr0) |-> r.tFirst == r.pre && r.tLast == 8'(r.pre + r.fsym - 8'h01);
  endproperty
  a_r17_sym: assert property (p_r17_sym) else $error("frame zero span wrong"); // R17
  property p_r18_idx;
    r.tVal |-> r.tIdx < r.ntiles && r.tile == r.tIdx + 16'h0001;
  endproperty
  a_r18_idx: assert property (p_r18_idx) else $error("tile index wrong"); // R18
  property p_r22_pulse;
    r.pReq |=> !r.pReq [*2];
  endproperty
  a_r22_pulse: assert property (p_r22_pulse) else $error("request not pulse"); // R22
  property p_r13_wrap;
    (r.ph == PH_ALLOC && advance && (IW+1)'(r.ptr) == r.sCnt - 1'b1) |=> r.ptr == '0;
  endproperty
  a_r13_wrap: assert property (p_r13_wrap) else $error("pointer wrap wrong"); // R13
  c_tile: cover property (r.tVal ##1 r.tVal);
  c_short: cover property (r.short && r.done);
  c_slave: cover property (r.ph == PH_SEC_HASH && r.hReq && tddSlave);
endmodule

// file: verilog/shata_pkg.sv
// Purpose: shared constants for sector hop seeding and ack tile allocation
// Assumes: single 250 MHz clock, APB register access
// Notes: How it works list below
// How it works
// R1: first offset is pilot code XOR low 12 superframe bits
// R2: second offset takes bits 7..5 from the superframe index
// R3: intra-cell flag selects second offset, else first offset
// R4: normal hash adds leading constant, q, c, s, j, offset; times golden
// R5: tdd seed code 1110 drops the constant and uses j divided by burst
// R6: seed is low 20 bits of the 32-bit bit reversal of the hash
// R7: sector permutation requested with size equal to non-guard block count
// R8: tile count zero without nodes, else max of two quotients
// R9: ack seed hashes ack constant, c, j and the first offset
// R10: ack seed requests a subband permutation of subband count size
// R11: ack seed requests a block permutation of blocks-per-subband size
// R12: pointer, tile counter and all block counters start at zero
// R13: pick subband at pointer, block at its counter, then advance both
// R14: reject guard blocks and control segment subbands
// R15: reject subbands whose restricted mask bit is one
// R16: accepted tile spans block-width subcarriers for the whole frame
// R17: fdd frame zero tiles cover preamble to preamble plus frame minus one
// R18: accepted tile takes counter as index; stop at tile count
// R19: subtile index is symbol divided by subtile duration
// R20: subtile holds block width times duration subcarriers
// R21: sector inputs come from the forward-link serving sector
// R22: seed and size go out with valid, entries read after done
// R23: seed code 1111 gives global hop the sector offset
package shata_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_PILOT = 8'h04;
  localparam logic [7:0] A_SFIDX = 8'h08;
  localparam logic [7:0] A_INDEX = 8'h0C;
  localparam logic [7:0] A_SEED  = 8'h10;
  localparam logic [7:0] A_NODES = 8'h14;
  localparam logic [7:0] A_MASK  = 8'h18;
  localparam logic [7:0] A_GEOM  = 8'h1C;
  localparam logic [7:0] A_TIME  = 8'h20;
  localparam logic [7:0] A_STAT  = 8'h24;
  localparam logic [7:0] A_SSEED = 8'h28;
  localparam logic [7:0] A_ASEED = 8'h2C;
  localparam logic [7:0] A_TILES = 8'h30;
  localparam logic [7:0] A_GOFF  = 8'h34;
  localparam logic [7:0] A_SYMQ  = 8'h38;
  localparam logic [7:0] A_SUBL  = 8'h3C;
  // field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_TDD   = 1;
  localparam int CTRL_INTRA = 2;
  localparam int IX_J = 0;
  localparam int IX_S = 8;
  localparam int IX_C = 16;
  localparam int IX_Q = 24;
  localparam int SD_BURST = 8;
  localparam int MK_CTL = 16;
  localparam int GM_B = 8;
  localparam int GM_NG = 16;
  localparam int TM_DUR = 8;
  localparam int TM_FSYM = 16;
  localparam int TM_PRE = 24;
  // hash term shifts and constants
  localparam int SH_Q = 24;
  localparam int SH_CSEC = 22;
  localparam int SH_S = 18;
  localparam int SH_CACK = 18;
  localparam int SH_J = 12;
  localparam logic [31:0] LEAD_SEC = 32'h0400_0000;
  localparam logic [31:0] LEAD_ACK = 32'h0040_0000;
  localparam logic [31:0] GOLDEN   = 32'h9E37_79B1;
  localparam logic [3:0]  CODE_TDD_SLAVE = 4'hE;
  localparam logic [3:0]  CODE_GLOB_SECT = 4'hF;
  // reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [7:0]  RST_ONE8  = 8'h01;
  typedef enum logic [3:0] {
    PH_IDLE, PH_SEC_HASH, PH_SEC_WAIT, PH_ACK_HASH, PH_SUB_WAIT,
    PH_SUB_RD, PH_BLK_WAIT, PH_BLK_RD, PH_ALLOC
  } shata_phase_type;
  function automatic logic [31:0] shata_bitrev(input logic [31:0] v);
    logic [31:0] o;
    o = '0;
    for (int k = 0; k < 32; k++)
    begin
      o[k] = v[31-k];
    end
    return o;
  endfunction
  // restoring division, zero divisor answers zero
  function automatic logic [23:0] shata_div(input logic [23:0] a,
                                            input logic [15:0] b);
    logic [23:0] q;
    logic [24:0] rem;
    q = '0;
    rem = '0;
    if (b != 16'h0000)
    begin
      for (int k = 23; k >= 0; k--)
      begin
        rem = {rem[23:0], a[k]};
        if (rem >= {9'h000, b})
        begin
          rem = rem - {9'h000, b};
          q[k] = 1'b1;
        end
      end
    end
    return q;
  endfunction
endpackage

// file: verilog/shata_hash_if.sv
// Purpose: carries hash requests between allocator and hash unit
// Assumes: req is a one-cycle pulse, done follows one cycle later
// Notes: seed holds until the next request
interface shata_hash_if;
  logic        req;
  logic [31:0] arg;
  logic        done;
  logic [19:0] seed;
  modport requester (output req, output arg, input done, input seed);
  modport hasher (input req, input arg, output done, output seed);
endinterface

// file: verilog/shata_seed_hash.sv
// Purpose: golden-ratio hash with 32-bit reversal, 20-bit seed out
// Assumes: one request in flight
// Notes: one cycle from req to done
module shata_seed_hash
  import shata_pkg::*;
(
  input  wire logic ref_clk,      // system clock
  input  wire logic sys_rst,      // sync reset, high
  shata_hash_if.hasher hif        // request and answer
);
  typedef struct packed {
    logic        done;
    logic [19:0] seed;
  } shata_hstate_type;
  shata_hstate_type r, n;
  logic [31:0] prod;

  // product wraps modulo 2^32 by width
  always_comb
  begin
    prod = hif.arg * GOLDEN;
    n = r;
    n.done = hif.req;
    if (hif.req)
    begin
      n.seed = 20'(shata_bitrev(prod)); // R6
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign hif.done = r.done;
  assign hif.seed = r.seed;

  property p_r6_seed;
    @(posedge ref_clk) disable iff (sys_rst)
      hif.req |=> hif.done && (hif.seed ==
        20'(shata_bitrev($past(hif.arg) * GOLDEN)));
  endproperty
  a_r6_seed: assert property (p_r6_seed) else $error("seed not bit reversal"); // R6
endmodule

// file: bench/shata_perm_model.sv
// Purpose: behavioural permutation generator on the far side
// Assumes: index reversal stands in for the real permutation
// Notes: completion alternates prompt and slow
module shata_perm_model
  import shata_pkg::*;
(
  input  wire logic        ref_clk,      // clock
  input  wire logic        sys_rst,      // sync reset
  input  wire logic        permReqValid, // request pulse
  input  wire logic [15:0] permSize,     // size
  output logic             permDone,     // completion pulse
  input  wire logic [3:0]  permRdAddr,   // entry index
  output logic [3:0]       permRdData    // entry value
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] size_ff;
  logic [2:0]  wait_ff;
  logic        slow_ff;
  // done only after a request, sometimes late so the wait is exercised
  always @(posedge ref_clk)
  begin
    permDone <= !sys_rst && wait_ff == 3'h1;
    if (sys_rst)
    begin
      wait_ff <= 3'h0;
      slow_ff <= 1'b0;
    end
    else if (permReqValid)
    begin
      size_ff <= permSize;
      wait_ff <= slow_ff ? 3'h6 : 3'h1;
      slow_ff <= !slow_ff;
    end
    else if (wait_ff != 3'h0)
      wait_ff <= wait_ff - 3'h1;
  end
  // past the size the entry is the inverted index, never a stale value
  assign permRdData = (permRdAddr < size_ff) ? 4'(size_ff - 16'h1 - permRdAddr) : ~permRdAddr;
endmodule

// file: bench/tb_shata_tile_alloc.sv
// Purpose: self-checking bench for seed hashing and ack tile allocation
// Assumes: partner returns the index-reversal permutation
// Notes: expectations are rebuilt here from the register field map
module tb_shata_tile_alloc
  import shata_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] PILOT = 12'hA5C;
  localparam logic [31:0] SFI = 32'h0001_23E5;
  localparam int S = 6, B = 4, NG = 3, BW = 8, DUR = 2, FS = 8, PRE = 4, BUR = 2;
  localparam int Q = 2, C = 1, SI = 3;
  localparam logic [15:0] RESTR = 16'h0004;
  localparam logic [15:0] CTL = 16'h0010;
  logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        permReqValid, permDone, tileValid, er;
  logic [7:0]  paddr, tileSymFirst, tileSymLast;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] permSeed;
  logic [15:0] permSize, tileIndex, tileSubcarrier;
  logic [3:0]  permRdAddr, permRdData, tileSubband, tileBlock;
  logic [11:0] globalHopOffset;
  logic [63:0] reqs[$];
  logic [63:0] tiles[$];
  int          err_count;
  int          comparisons;

  shata_tile_alloc #(.PERM_MAX(16)) uut (.ref_clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .permReqValid, .permSeed, .permSize,
    .permDone, .permRdAddr, .permRdData, .tileValid, .tileIndex, .tileSubband,
    .tileBlock, .tileSubcarrier, .tileSymFirst, .tileSymLast, .globalHopOffset);
  shata_perm_model partner (.ref_clk, .sys_rst, .permReqValid, .permSize, .permDone,
    .permRdAddr, .permRdData);

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  function automatic logic [31:0] seed20(input longint t);
    logic [31:0] m;
    logic [31:0] o;
    m = 32'(t * 64'h9E37_79B1);
    for (int k = 0; k < 32; k++)
      o[k] = m[31 - k];
    return {12'h000, o[19:0]};
  endfunction

  // configure, start, wait for done, then check seeds, requests and tiles
  task automatic run(input logic tdd, input logic intra, input logic [3:0] code,
                     input logic [5:0] j, input logic [15:0] nodes);
    logic [11:0] o1, off;
    logic [31:0] ss, aSeed;
    logic [63:0] expT[$];
    logic [7:0]  ad[5];
    logic [31:0] ex[5];
    int          cnt[16];
    int          nt, pt, acc, tried, sb, bk, n;
    logic        fr0;
    o1 = PILOT ^ SFI[11:0];
    off = intra ? {o1[11:8], SFI[7:5], o1[4:0]} : o1;
    fr0 = !tdd && j == 6'h00;
    ss = seed20(Q*4*16*64*4096 + C*16*64*4096 + SI*64*4096 + off + ((tdd && code == 4'hE) ?
         (j / BUR) * 4096 : 4*4*16*64*4096 + j*4096));
    aSeed = seed20(4*4*64*4096 + C*64*4096 + j*4096 + o1);
    nt = (nodes == 0) ? 0 : (2*nodes/(DUR*BW) > FS/DUR) ? 2*nodes/(DUR*BW) : FS/DUR;
    pt = 0;
    acc = 0;
    tried = 0;
    cnt = '{default: 0};
    while (acc < nt && tried < S*B)
    begin
      sb = S - 1 - pt;
      bk = B - 1 - cnt[sb];
      cnt[sb]++;
      pt = (pt + 1) % S;
      tried++;
      if (bk < NG && !RESTR[sb] && !CTL[sb])
      begin
        expT.push_back({8'h00, 16'(acc), 4'(sb), 4'(bk), 16'((sb*B + bk)*BW),
                        fr0 ? 8'(PRE) : 8'h00, fr0 ? 8'(PRE + FS - 1) : 8'(FS - 1)});
        acc++;
      end
    end
    reqs.delete();
    tiles.delete();
    apb(A_PILOT, 1'b1, {20'h0_0000, PILOT});
    apb(A_SFIDX, 1'b1, SFI);
    apb(A_INDEX, 1'b1, {6'h00, 2'(Q), 6'h00, 2'(C), 4'h0, 4'(SI), 2'h0, j});
    apb(A_SEED, 1'b1, {16'h0000, 8'(BUR), 4'h0, code});
    apb(A_NODES, 1'b1, {16'h0000, nodes});
    apb(A_MASK, 1'b1, {CTL, RESTR});
    apb(A_GEOM, 1'b1, {11'h000, 5'(NG), 3'h0, 5'(B), 3'h0, 5'(S)});
    apb(A_TIME, 1'b1, {8'(PRE), 8'(FS), 8'(DUR), 8'(BW)});
    apb(A_CTRL, 1'b1, {29'h0000_0000, intra, tdd, 1'b1});
    n = 0;
    do
      apb(A_STAT, 1'b0, 32'h0000_0000);
    while (rd[1:0] !== 2'b10 && ++n < 300);
    chk(rd[2], acc < nt);
    ad = '{A_SSEED, A_ASEED, A_TILES, A_GOFF, A_SUBL};
    ex = '{ss, aSeed, {8'h00, 8'(FS/DUR), 16'(nt)},
           {20'h0_0000, (code == 4'hF) ? off : SFI[11:0]}, 32'(BW*DUR)};
    for (int k = 0; k < 5; k++)
    begin
      apb(ad[k], 1'b0, 32'h0000_0000);
      chk(rd, ex[k]);
    end
    chk(globalHopOffset, ex[3]);
    chk(reqs.size(), 3);
    chk(reqs[0], {24'h00_0000, 16'(NG), 4'h0, ss[19:0]});
    chk(reqs[1], {24'h00_0000, 16'(S), 4'h0, aSeed[19:0]});
    chk(reqs[2], {24'h00_0000, 16'(B), 4'h0, aSeed[19:0]});
    chk(tiles.size(), expT.size());
    foreach (expT[k])
      chk(tiles[k], expT[k]);
  endtask

  // capture generator requests and tiles as the design presents them
  always @(posedge ref_clk)
  begin
    if (permReqValid === 1'b1)
      reqs.push_back({24'h00_0000, permSize, 4'h0, permSeed});
    if (tileValid === 1'b1)
      tiles.push_back({8'h00, tileIndex, tileSubband, tileBlock, tileSubcarrier,
                       tileSymFirst, tileSymLast});
  end

  // cut a hang short well beyond the few hundred cycles the tests need
  initial
  begin
    #40000;
    err_count++;
    wrap_up();
  end

  initial
  begin
    err_count = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(A_SEED, 1'b0, 32'h0000_0000);
    chk({er, rd}, 33'h0_0000_0100);
    apb(A_STAT, 1'b0, 32'h0000_0000);
    chk({er, rd}, 33'h0_0000_0000);
    apb(8'h40, 1'b0, 32'h0000_0000);
    chk({er, rd}, 33'h1_0000_0000);
    apb(8'h06, 1'b0, 32'h0000_0000);
    chk({er, rd}, 33'h1_0000_0000);
    run(1'b0, 1'b0, 4'hF, 6'h00, 16'h0014);
    run(1'b1, 1'b1, 4'hE, 6'h05, 16'h00C8);
    run(1'b0, 1'b1, 4'h3, 6'h02, 16'h0000);
    apb(A_SYMQ, 1'b1, 32'h0000_0007);
    apb(A_SYMQ, 1'b0, 32'h0000_0000);
    chk(rd[31:16], 16'(7/DUR));
    wrap_up();
  end
endmodule
